//--- rtl/iev_pkg.sv
// interrupt enable and vectoring: shared constants
// assumes one system clock and an 8-bit special-function register bus on the core side
package iev_pkg;

    // ==========================================================
    // register map
    localparam logic [7:0]  IEV_ENABLE_ADDR   = 8'ha8;
    localparam logic [7:0]  IEV_ENABLE_RESET  = 8'h00;
    localparam logic [4:0]  IEV_ENABLE_BITROW = 5'h15;   // bit addresses 0xa8..0xaf

    // ==========================================================
    // enable register fields
    localparam int IEV_BIT_GLOBAL   = 7;
    localparam int IEV_BIT_SPI      = 6;
    localparam int IEV_BIT_TIMER2   = 5;
    localparam int IEV_BIT_UART     = 4;
    localparam int IEV_BIT_TIMER1   = 3;
    localparam int IEV_BIT_EXT1     = 2;
    localparam int IEV_BIT_TIMER0   = 1;
    localparam int IEV_BIT_EXT0     = 0;

    // ==========================================================
    // sources and vectors
    localparam int           IEV_NUM_SRC      = 18;
    localparam int           IEV_NUM_OTHER    = 11;   // sources 7..17, enabled outside this block
    localparam int           IEV_IDX_W        = 5;
    localparam logic [15:0]  IEV_RESET_VECTOR = 16'h0000;
    localparam logic [15:0]  IEV_VECTOR_BASE  = 16'h0003;
    localparam int           IEV_VECTOR_SHIFT = 3;    // eight bytes per vector
    localparam logic [17:0]  IEV_HW_CLEAR     = 18'h1_000f;   // sources 0..3 and 16

    // ==========================================================
    // timing
    localparam logic [2:0]   IEV_CALL_CYCLES  = 3'h4;

    typedef enum logic {IEV_ST_RUN, IEV_ST_CALL} iev_state_t;

endpackage : iev_pkg

//--- rtl/iev_src_gate.sv
// one source's request: any pending flag, gated by its own and the global enable
// assumes flags come from logic on the system clock
module iev_src_gate #(
    parameter int NUM_FLAGS = 1
) (
    input  wire logic [NUM_FLAGS-1:0] i_flags,
    input  wire logic                 i_src_enable,
    input  wire logic                 i_global_enable,
    output logic                      o_req
);
    assign o_req = (|i_flags) & i_src_enable & i_global_enable;
endmodule : iev_src_gate

//--- rtl/iev_prio_pick.sv
// fixed-order pick: the lowest index among active requests wins
// assumes a combinational path is acceptable in the caller
module iev_prio_pick import iev_pkg::*; #(
    parameter int N = IEV_NUM_SRC
) (
    input  wire logic [N-1:0]         i_req,
    output logic                      o_any,
    output logic [IEV_IDX_W-1:0]      o_index
);
    always_comb begin
        o_any   = 1'b0;
        o_index = '0;
        for (int k = N - 1; k >= 0; k--) begin
            if (i_req[k]) begin
                o_any   = 1'b1;
                o_index = IEV_IDX_W'(k);
            end
        end
    end
endmodule : iev_prio_pick

//--- rtl/iev_ctrl.sv
// interrupt enable, arbitration and vectoring for the processor core
// assumes pending flags and core strobes are synchronous to i_clk_sys
module iev_ctrl import iev_pkg::*; (
    input  wire logic                     i_clk_sys,
    input  wire logic                     i_sys_rst,
    input  wire logic                     i_clk_en,
    input  wire logic [7:0]               i_sfr_addr,
    input  wire logic                     i_sfr_wr,
    input  wire logic [7:0]               i_sfr_wdata,
    input  wire logic                     i_sfr_rd,
    input  wire logic                     i_sfr_bit_wr,
    input  wire logic [7:0]               i_sfr_bit_addr,
    input  wire logic                     i_sfr_bit_wdata,
    input  wire logic                     i_ext_pin_zero_flag,
    input  wire logic                     i_timer_zero_overflow_flag,
    input  wire logic                     i_ext_pin_one_flag,
    input  wire logic                     i_timer_one_overflow_flag,
    input  wire logic                     i_uart_rx_flag,
    input  wire logic                     i_uart_tx_flag,
    input  wire logic                     i_timer_two_low_overflow_flag,
    input  wire logic                     i_timer_two_high_overflow_flag,
    input  wire logic [3:0]               i_serial_periph_flags,
    input  wire logic [IEV_NUM_OTHER-1:0] i_other_src_flags,
    input  wire logic [IEV_NUM_OTHER-1:0] i_other_src_enable,
    input  wire logic [IEV_NUM_SRC-1:0]   i_src_high_prio,
    input  wire logic                     i_insn_done,
    input  wire logic                     i_insn_is_return_from_interrupt,
    output logic [7:0]                    o_sfr_rdata,
    output logic [7:0]                    o_enable_mask,
    output logic                          o_long_call,
    output logic                          o_vector_valid,
    output logic [15:0]                   o_vector_addr,
    output logic [IEV_NUM_SRC-1:0]        o_flag_clear,
    output logic                          o_in_service_high,
    output logic                          o_in_service_low
);

    // ==========================================================
    // enable register
    logic [7:0] interrupt_enable_mask_reg, interrupt_enable_mask_next;
    logic [7:0] rdata_reg, rdata_next;
    logic       global_irq_gate;

    always_comb begin
        interrupt_enable_mask_next = interrupt_enable_mask_reg;
        rdata_next                 = rdata_reg;
        if (i_sfr_wr && i_sfr_addr == IEV_ENABLE_ADDR) begin
            interrupt_enable_mask_next = i_sfr_wdata;
        end
        if (i_sfr_bit_wr && i_sfr_bit_addr[7:3] == IEV_ENABLE_BITROW) begin
            interrupt_enable_mask_next[i_sfr_bit_addr[2:0]] = i_sfr_bit_wdata;
        end
        if (i_sfr_rd) begin
            rdata_next = (i_sfr_addr == IEV_ENABLE_ADDR) ? interrupt_enable_mask_reg : 8'h00;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            interrupt_enable_mask_reg <= IEV_ENABLE_RESET;
            rdata_reg                 <= 8'h00;
        end else if (i_clk_en) begin
            interrupt_enable_mask_reg <= interrupt_enable_mask_next;
            rdata_reg                 <= rdata_next;
        end
    end

    assign global_irq_gate = interrupt_enable_mask_reg[IEV_BIT_GLOBAL];
    assign o_sfr_rdata     = rdata_reg;
    assign o_enable_mask   = interrupt_enable_mask_reg;

    // ==========================================================
    // per-source gating
    logic [IEV_NUM_SRC-1:0] req_raw;

    iev_src_gate #(.NUM_FLAGS(1)) u_ext0 (
        .i_flags         (i_ext_pin_zero_flag),
        .i_src_enable    (interrupt_enable_mask_reg[IEV_BIT_EXT0]),
        .i_global_enable (global_irq_gate),
        .o_req           (req_raw[0])
    );
    iev_src_gate #(.NUM_FLAGS(1)) u_tmr0 (
        .i_flags         (i_timer_zero_overflow_flag),
        .i_src_enable    (interrupt_enable_mask_reg[IEV_BIT_TIMER0]),
        .i_global_enable (global_irq_gate),
        .o_req           (req_raw[1])
    );
    iev_src_gate #(.NUM_FLAGS(1)) u_ext1 (
        .i_flags         (i_ext_pin_one_flag),
        .i_src_enable    (interrupt_enable_mask_reg[IEV_BIT_EXT1]),
        .i_global_enable (global_irq_gate),
        .o_req           (req_raw[2])
    );
    iev_src_gate #(.NUM_FLAGS(1)) u_tmr1 (
        .i_flags         (i_timer_one_overflow_flag),
        .i_src_enable    (interrupt_enable_mask_reg[IEV_BIT_TIMER1]),
        .i_global_enable (global_irq_gate),
        .o_req           (req_raw[3])
    );
    iev_src_gate #(.NUM_FLAGS(2)) u_uart (
        .i_flags         ({i_uart_tx_flag, i_uart_rx_flag}),
        .i_src_enable    (interrupt_enable_mask_reg[IEV_BIT_UART]),
        .i_global_enable (global_irq_gate),
        .o_req           (req_raw[4])
    );
    iev_src_gate #(.NUM_FLAGS(2)) u_tmr2 (
        .i_flags         ({i_timer_two_high_overflow_flag, i_timer_two_low_overflow_flag}),
        .i_src_enable    (interrupt_enable_mask_reg[IEV_BIT_TIMER2]),
        .i_global_enable (global_irq_gate),
        .o_req           (req_raw[5])
    );
    iev_src_gate #(.NUM_FLAGS(4)) u_spi (
        .i_flags         (i_serial_periph_flags),
        .i_src_enable    (interrupt_enable_mask_reg[IEV_BIT_SPI]),
        .i_global_enable (global_irq_gate),
        .o_req           (req_raw[6])
    );

    // extended sources: enables live in registers outside this block
    for (genvar g = 0; g < IEV_NUM_OTHER; g++) begin : g_other
        iev_src_gate #(.NUM_FLAGS(1)) u_gate (
            .i_flags         (i_other_src_flags[g]),
            .i_src_enable    (i_other_src_enable[g]),
            .i_global_enable (global_irq_gate),
            .o_req           (req_raw[g + 7])
        );
    end

    // ==========================================================
    // sampling and arbitration
    logic [IEV_NUM_SRC-1:0] req_reg, req_next;
    logic [IEV_NUM_SRC-1:0] hi_req, lo_req;
    logic                   hi_any, lo_any, take_hi, take_lo, start_call, boundary;
    logic [IEV_IDX_W-1:0]   hi_idx, lo_idx, sel_idx;

    assign req_next = req_raw;
    assign hi_req   = req_reg & i_src_high_prio;
    assign lo_req   = req_reg & ~i_src_high_prio;

    iev_prio_pick #(.N(IEV_NUM_SRC)) u_pick_hi (
        .i_req   (hi_req),
        .o_any   (hi_any),
        .o_index (hi_idx)
    );
    iev_prio_pick #(.N(IEV_NUM_SRC)) u_pick_lo (
        .i_req   (lo_req),
        .o_any   (lo_any),
        .o_index (lo_idx)
    );

    // ==========================================================
    // vectoring sequence
    iev_state_t             state_reg, state_next;
    logic [2:0]             cnt_reg, cnt_next;
    logic [IEV_IDX_W-1:0]   src_reg, src_next;
    logic                   svc_high_reg, svc_high_next, svc_low_reg, svc_low_next;
    logic                   vvalid_reg, vvalid_next;
    logic [15:0]            vaddr_reg, vaddr_next;
    logic [IEV_NUM_SRC-1:0] clear_reg, clear_next;

    // a completing return is never a boundary, so one more instruction runs first
    assign boundary   = i_insn_done & ~i_insn_is_return_from_interrupt;
    assign take_hi    = hi_any & ~svc_high_reg;
    assign take_lo    = lo_any & ~svc_high_reg & ~svc_low_reg;
    assign start_call = (state_reg == IEV_ST_RUN) & boundary & (take_hi | take_lo);
    assign sel_idx    = take_hi ? hi_idx : lo_idx;

    always_comb begin
        state_next    = state_reg;
        cnt_next      = cnt_reg;
        src_next      = src_reg;
        svc_high_next = svc_high_reg;
        svc_low_next  = svc_low_reg;
        vvalid_next   = 1'b0;
        vaddr_next    = vaddr_reg;
        clear_next    = '0;
        unique case (state_reg)
            IEV_ST_RUN: begin
                if (i_insn_done && i_insn_is_return_from_interrupt) begin
                    if (svc_high_reg) begin
                        svc_high_next = 1'b0;
                    end else begin
                        svc_low_next = 1'b0;
                    end
                end
                if (start_call) begin
                    state_next = IEV_ST_CALL;
                    cnt_next   = 3'h0;
                    src_next   = sel_idx;
                    if (take_hi) begin
                        svc_high_next = 1'b1;
                    end else begin
                        svc_low_next = 1'b1;
                    end
                end
            end
            IEV_ST_CALL: begin
                cnt_next = cnt_reg + 3'h1;
                if (cnt_reg == IEV_CALL_CYCLES - 3'h1) begin
                    state_next  = IEV_ST_RUN;
                    vvalid_next = 1'b1;
                    vaddr_next  = IEV_VECTOR_BASE + (16'(src_reg) << IEV_VECTOR_SHIFT);
                    clear_next  = IEV_HW_CLEAR & (IEV_NUM_SRC'(1) << src_reg);
                end
            end
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            state_reg    <= IEV_ST_RUN;
            cnt_reg      <= 3'h0;
            src_reg      <= '0;
            svc_high_reg <= 1'b0;
            svc_low_reg  <= 1'b0;
            vvalid_reg   <= 1'b0;
            vaddr_reg    <= IEV_RESET_VECTOR;
            clear_reg    <= '0;
            req_reg      <= '0;
        end else if (i_clk_en) begin
            state_reg    <= state_next;
            cnt_reg      <= cnt_next;
            src_reg      <= src_next;
            svc_high_reg <= svc_high_next;
            svc_low_reg  <= svc_low_next;
            vvalid_reg   <= vvalid_next;
            vaddr_reg    <= vaddr_next;
            clear_reg    <= clear_next;
            req_reg      <= req_next;
        end
    end

    assign o_long_call       = (state_reg == IEV_ST_CALL);
    assign o_vector_valid    = vvalid_reg;
    assign o_vector_addr     = vaddr_reg;
    assign o_flag_clear      = clear_reg;
    assign o_in_service_high = svc_high_reg;
    assign o_in_service_low  = svc_low_reg;

    // ==========================================================
    // checks
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst || !i_clk_en);

    sequence call_run_s;
        o_long_call [*4] ##1 (!o_long_call && o_vector_valid);
    endsequence

    call_length_a: assert property (start_call |=> call_run_s)
        else $error("long call not four cycles then vector");
    vector_addr_a: assert property (o_vector_valid |-> o_vector_addr[2:0] == 3'h3 && o_vector_addr <= 16'h008b)
        else $error("vector address off grid");
    return_from_interrupt_no_call_a: assert property (!o_long_call && i_insn_done && i_insn_is_return_from_interrupt |=> !o_long_call)
        else $error("call issued at return boundary");
    global_gate_a: assert property (!interrupt_enable_mask_reg[IEV_BIT_GLOBAL] |=> req_reg == '0)
        else $error("request with global gate off");
    sample_a: assert property ($rose(|req_raw) |=> |req_reg)
        else $error("request not sampled next clock");
    high_no_preempt_a: assert property (svc_high_reg |-> !start_call)
        else $error("high-level routine preempted");
    same_level_a: assert property (svc_low_reg && start_call |-> take_hi)
        else $error("equal level request serviced");
    lowest_first_a: assert property (start_call && take_hi
                                     |-> (hi_req & ((IEV_NUM_SRC'(1) << sel_idx) - IEV_NUM_SRC'(1))) == '0)
        else $error("higher order source beat lower");
    low_order_a: assert property (start_call && !take_hi
                                  |-> (lo_req & ((IEV_NUM_SRC'(1) << sel_idx) - IEV_NUM_SRC'(1))) == '0)
        else $error("low level order broken");
    auto_clear_a: assert property (o_flag_clear != '0 |-> o_vector_valid && $past(o_long_call))
        else $error("flag clear outside vectoring");
    sfr_write_a: assert property (i_sfr_wr && i_sfr_addr == IEV_ENABLE_ADDR && !i_sfr_bit_wr
                                  |=> interrupt_enable_mask_reg == $past(i_sfr_wdata))
        else $error("enable register write lost");
    call_count_a: assert property (o_long_call |-> cnt_reg < IEV_CALL_CYCLES)
        else $error("call counter past its end");
    // frozen block keeps its register and its place in the call sequence
    enable_freeze_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
                                      !i_clk_en |=> $stable(state_reg) && $stable(cnt_reg)
                                                    && $stable(interrupt_enable_mask_reg))
        else $error("state moved with clock enable low");

endmodule : iev_ctrl

//--- tb/iev_core_model.sv
// core model: retires one instruction every gap+1 cycles, can return from a routine
// assumes the controller's long-call output is registered
module iev_core_model (
    input  wire logic       i_clk_sys,
    input  wire logic       i_sys_rst,
    input  wire logic [3:0] i_gap,
    input  wire logic       i_return_from_interrupt,
    input  wire logic       i_long_call,
    output logic            o_insn_done,
    output logic            o_insn_is_return_from_interrupt
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_reg;
    logic       return_from_interrupt_reg;
    // ========
    // pacing
    // no retirement while the long call owns the core
    assign o_insn_done    = (cnt_reg == 4'h0) && !i_long_call && !i_sys_rst;
    assign o_insn_is_return_from_interrupt = return_from_interrupt_reg && o_insn_done;
    always @(posedge i_clk_sys) begin
        if (i_sys_rst || o_insn_done)
            cnt_reg <= i_gap;
        else if (cnt_reg != 4'h0)
            cnt_reg <= cnt_reg - 4'h1;
        if (i_sys_rst || o_insn_is_return_from_interrupt)
            return_from_interrupt_reg <= 1'b0;
        else if (i_return_from_interrupt)
            return_from_interrupt_reg <= 1'b1;
    end
endmodule : iev_core_model

//--- tb/tb.sv
// self-checking bench for the interrupt controller: register, gating, vectors, nesting
// assumes iev_core_model paces the core; peripheral flags are modelled here
module tb import iev_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, rst = 1'b1, en = 1'b1, wr = 1'b0, rd = 1'b0, bwr = 1'b0, bdat = 1'b0, return_from_interrupt = 1'b0;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, baddr = 8'h00, rdata, mask, m;
    logic [17:0] src_flag = 18'h0, hi_prio = 18'h0, fclr;
    logic [10:0] oth_en = 11'h7ff;
    logic [1:0]  sub = 2'h0;
    logic [3:0]  gap = 4'h0;
    logic [15:0] vaddr;
    logic        long_call, vvalid, ish, isl, done, is_return_from_interrupt;
    int          err_total = 0, checks_done = 0, cyc = 0, n, k, s, a;

    iev_ctrl dut (
        .i_clk_sys(clk), .i_sys_rst(rst), .i_clk_en(en), .i_sfr_addr(addr), .i_sfr_wr(wr), .i_sfr_wdata(wdata),
        .i_sfr_rd(rd), .i_sfr_bit_wr(bwr), .i_sfr_bit_addr(baddr), .i_sfr_bit_wdata(bdat),
        .i_ext_pin_zero_flag(src_flag[0]), .i_timer_zero_overflow_flag(src_flag[1]),
        .i_ext_pin_one_flag(src_flag[2]), .i_timer_one_overflow_flag(src_flag[3]),
        .i_uart_rx_flag(src_flag[4] & ~sub[0]), .i_uart_tx_flag(src_flag[4] & sub[0]),
        .i_timer_two_low_overflow_flag(src_flag[5] & ~sub[1]),
        .i_timer_two_high_overflow_flag(src_flag[5] & sub[1]),
        .i_serial_periph_flags({4{src_flag[6]}} & (4'h1 << sub)), .i_other_src_flags(src_flag[17:7]),
        .i_other_src_enable(oth_en), .i_src_high_prio(hi_prio), .i_insn_done(done), .i_insn_is_return_from_interrupt(is_return_from_interrupt),
        .o_sfr_rdata(rdata), .o_enable_mask(mask), .o_long_call(long_call), .o_vector_valid(vvalid),
        .o_vector_addr(vaddr), .o_flag_clear(fclr), .o_in_service_high(ish), .o_in_service_low(isl));
    iev_core_model core (.i_clk_sys(clk), .i_sys_rst(rst), .i_gap(gap), .i_return_from_interrupt(return_from_interrupt), .i_long_call(long_call),
        .o_insn_done(done), .o_insn_is_return_from_interrupt(is_return_from_interrupt));

    always #5 clk = ~clk;
    // peripherals drop only the flags the controller clears, so software clears never race it
    always @(posedge clk) if (vvalid === 1'b1) foreach (fclr[i]) if (fclr[i]) src_flag[i] <= 1'b0;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            results();
        end
    end

    // ========
    // helpers
    task automatic chk(input logic [17:0] got, input logic [17:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic sfr_wr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge clk);
        addr  <= ad;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : sfr_wr
    task automatic sfr_rd(input logic [7:0] ad, input logic [7:0] e);
        @(posedge clk);
        addr <= ad;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(18'(rdata), 18'(e), "read data");
    endtask : sfr_rd
    task automatic set_flag(input int f);
        @(posedge clk);
        src_flag[f] <= 1'b1;
        sub         <= 2'($urandom);
        gap         <= 4'($urandom_range(0, 3));
    endtask : set_flag
    task automatic quiet(input int c);
        repeat (c) begin
            @(negedge clk);
            chk(18'(long_call), 18'h0, "unexpected call");
        end
    endtask : quiet
    task automatic expect_vec(input int f);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (long_call !== 1'b1 && n < 80);
        k = 0;
        while (long_call === 1'b1 && k < 9) begin
            @(negedge clk);
            k++;
        end
        chk(18'(k), 18'h4, "call length");
        chk(18'(vvalid), 18'h1, "vector strobe");
        chk(18'(vaddr), 18'(IEV_VECTOR_BASE + 16'(8 * f)), "vector");
        chk(fclr, IEV_HW_CLEAR[f] ? 18'h1 << f : 18'h0, "flag clear");
    endtask : expect_vec
    task automatic isr_end(input int f);
        @(posedge clk);
        src_flag[f] <= 1'b0;
        return_from_interrupt        <= 1'b1;
        @(posedge clk);
        return_from_interrupt <= 1'b0;
    endtask : isr_end
    task automatic results();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : results

    // ========
    // sequence
    initial begin
        void'($urandom(85410));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk(18'(mask), 18'h0, "reset mask");
        chk(18'(vaddr), 18'h0, "reset vector");
        m = 8'($urandom);
        sfr_wr(8'ha8, m);
        sfr_rd(8'ha8, m);
        sfr_rd(8'hb8, 8'h00);
        for (a = 0; a < 8; a++) begin
            @(posedge clk);
            baddr <= IEV_ENABLE_ADDR + 8'(a);
            bdat  <= ~m[a];
            bwr   <= 1'b1;
            @(posedge clk);
            bwr  <= 1'b0;
            m[a] = ~m[a];
            @(negedge clk);
            chk(18'(mask), 18'(m), "bit write");
        end
        sfr_wr(8'ha8, 8'h7f);
        @(posedge clk);
        src_flag <= 18'h3_ffff;
        quiet(20);
        @(posedge clk);
        src_flag <= 18'h0;
        for (s = 0; s < 7; s++) begin
            m = 8'($urandom) | 8'h80;
            m[s] = 1'b0;
            sfr_wr(8'ha8, m);
            set_flag(s);
            quiet(12);
            sfr_wr(8'ha8, m | (8'h1 << s));
            expect_vec(s);
            isr_end(s);
            repeat (8) @(posedge clk);
        end
        gap <= 4'h0;
        sfr_wr(8'ha8, 8'hff);
        @(posedge clk);
        src_flag[0] <= 1'b1;
        repeat (2) @(negedge clk) chk(18'(long_call), 18'h0, "early call");
        expect_vec(0);
        chk(18'(n), 18'h1, "best-case start");
        isr_end(0);
        repeat (8) @(posedge clk);
        // frozen clock enable: a write is lost while a pending flag waits
        @(posedge clk);
        en          <= 1'b0;
        src_flag[3] <= 1'b1;
        sfr_wr(8'ha8, 8'h00);
        quiet(6);
        chk(18'(mask), 18'hff, "frozen mask");
        @(posedge clk);
        en <= 1'b1;
        expect_vec(3);
        isr_end(3);
        repeat (8) @(posedge clk);
        for (a = 0; a < 6; a++) begin
            s = (a < 2) ? 16 + a : $urandom_range(7, 17);
            set_flag(s);
            expect_vec(s);
            isr_end(s);
            repeat (8) @(posedge clk);
        end
        a = $urandom_range(0, 16);
        s = $urandom_range(a + 1, 17);
        @(posedge clk);
        src_flag[a] <= 1'b1;
        src_flag[s] <= 1'b1;
        expect_vec(a);
        isr_end(a);
        expect_vec(s);
        isr_end(s);
        repeat (8) @(posedge clk);
        set_flag(4);
        expect_vec(4);
        set_flag(1);
        quiet(15);
        @(posedge clk);
        hi_prio <= 18'h5;
        src_flag[2] <= 1'b1;
        expect_vec(2);
        chk(18'({ish, isl}), 18'h3, "nesting levels");
        set_flag(0);
        quiet(15);
        isr_end(2);
        expect_vec(0);
        isr_end(0);
        quiet(15);
        isr_end(4);
        expect_vec(1);
        isr_end(1);
        repeat (8) @(posedge clk);
        hi_prio <= 18'h0;
        @(posedge clk);
        src_flag[4] <= 1'b1;
        gap         <= 4'h3;
        expect_vec(4);
        @(posedge clk);
        return_from_interrupt <= 1'b1;
        @(posedge clk);
        return_from_interrupt <= 1'b0;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (!(done === 1'b1 && is_return_from_interrupt === 1'b1) && n < 40);
        k = 0;
        n = 0;
        do begin
            @(negedge clk);
            n++;
            if (done === 1'b1) k++;
        end while (long_call !== 1'b1 && n < 40);
        chk(18'(k), 18'h1, "insns before re-entry");
        isr_end(4);
        repeat (8) @(posedge clk);
        results();
    end
endmodule : tb
